/* File: hw/lane_slot_register.sv */
`timescale 1ns/1ps

module lane_slot_register (
    input  wire logic       pixelClock,
    input  wire logic       blank,
    input  wire logic [6:0] slotsIn,
    output logic      [6:0] slotsOut
);

    // One lane worth of slots, cleared while the link is not usable
    always_ff @(posedge pixelClock) begin
        if (blank) begin
            slotsOut <= 7'h00;
        end else begin
            slotsOut <= slotsIn;
        end
    end

endmodule : lane_slot_register

/* File: hw/pixel_lane_serializer.sv */
`timescale 1ns/1ps

module pixel_lane_serializer #(
    parameter bit HAS_STROBE_SELECT = 1'b1,
    parameter int LOCK_CYCLES       = pixel_lane_pkg::LOCK_CYCLES
) (
    input  wire logic                           mclk,
    input  wire logic                           reset_n,
    input  wire logic                           pixelClockIn,
    input  wire pixel_lane_pkg::pixel_word_type parallelPixelIn,
    input  wire logic                           strobeRising,
    input  wire logic                           powerDown_n,
    output pixel_lane_pkg::lane_words_type      serialLaneOut,
    output logic      [6:0]                     clockLaneOut,
    output logic                                laneOutEnable,
    output logic                                linkReady
);

    // Pixel domain state
    logic                           pixRstSync1_q;
    logic                           pixRstSync2_q;
    logic                           lockSync1_q;
    logic                           lockSync2_q;
    logic                           strobeSync1_q;
    logic                           strobeSync2_q;
    logic                           useRising;
    logic [1:0]                     actDiv_q;
    pixel_lane_pkg::pixel_word_type risingWord_q;
    pixel_lane_pkg::pixel_word_type fallingWord_q;
    pixel_lane_pkg::pixel_word_type capturedWord_d;
    pixel_lane_pkg::pixel_word_type capturedWord_q;
    pixel_lane_pkg::lane_words_type mappedLanes;

    // Mclk domain state
    logic                                   pdSync1_q;
    logic                                   pdSync2_q;
    logic                                   actSync1_q;
    logic                                   actSync2_q;
    logic                                   actSync3_q;
    logic [pixel_lane_pkg::ACT_CNT_BITS-1:0] idleCount_q;
    logic                                   clockPresent;
    logic [pixel_lane_pkg::LOCK_CNT_BITS-1:0] lockCount_q;
    logic [pixel_lane_pkg::LOCK_CNT_BITS-1:0] lockTarget;

    assign lockTarget = pixel_lane_pkg::LOCK_CNT_BITS'(LOCK_CYCLES);

    // Fixed slot map shared with the receiver, slot 0 sent first
    function automatic pixel_lane_pkg::lane_words_type mapLanes(
        input pixel_lane_pkg::pixel_word_type w
    );
        pixel_lane_pkg::lane_words_type l;
        l[0] = {w.green[0], w.red[5:0]};
        l[1] = {w.blue[1:0], w.green[5:1]};
        l[2] = {w.pixelDataValid, w.frameSync, w.lineSync, w.blue[5:2]};
        l[3] = {w.spareCtl, w.blue[7:6], w.green[7:6], w.red[7:6]};
        return l;
    endfunction : mapLanes

    // Pixel clock domain

    // Bring reset into the pixel domain; clock may stop, so plain chain
    always_ff @(posedge pixelClockIn) begin
        pixRstSync1_q <= reset_n;
        pixRstSync2_q <= pixRstSync1_q;
    end

    // Lock status from mclk, a level, so two flops suffice
    always_ff @(posedge pixelClockIn) begin
        if (!pixRstSync2_q) begin
            lockSync1_q <= 1'b0;
            lockSync2_q <= 1'b0;
        end else begin
            lockSync1_q <= linkReady;
            lockSync2_q <= lockSync1_q;
        end
    end

    // Strobe select is a static strap pin, still synchronised
    always_ff @(posedge pixelClockIn) begin
        if (!pixRstSync2_q) begin
            strobeSync1_q <= 1'b0;
            strobeSync2_q <= 1'b0;
        end else begin
            strobeSync1_q <= strobeRising;
            strobeSync2_q <= strobeSync1_q;
        end
    end

    // Variant without the pin is fixed to falling edge
    assign useRising = HAS_STROBE_SELECT & strobeSync2_q;

    // Slow activity toggle so mclk can see the pixel clock running
    always_ff @(posedge pixelClockIn) begin
        if (!pixRstSync2_q) begin
            actDiv_q <= pixel_lane_pkg::ACT_DIV_RESET;
        end else begin
            actDiv_q <= actDiv_q + 2'h1;
        end
    end

    // Rising edge capture of the parallel word
    always_ff @(posedge pixelClockIn) begin
        if (!pixRstSync2_q) begin
            risingWord_q <= '0;
        end else begin
            risingWord_q <= parallelPixelIn;
        end
    end

    // Falling edge capture; half a cycle to reach the rising flops
    always_ff @(negedge pixelClockIn) begin
        if (!pixRstSync2_q) begin
            fallingWord_q <= '0;
        end else begin
            fallingWord_q <= parallelPixelIn;
        end
    end

    // Both captures retimed to one edge, so lane format never differs
    always_comb begin
        if (useRising) begin
            capturedWord_d = risingWord_q;
        end else begin
            capturedWord_d = fallingWord_q;
        end
    end

    always_ff @(posedge pixelClockIn) begin
        if (!pixRstSync2_q) begin
            capturedWord_q <= '0;
        end else begin
            capturedWord_q <= capturedWord_d;
        end
    end

    // All 28 bits placed, none dropped or altered
    assign mappedLanes = mapLanes(capturedWord_q);

    // Four data lanes plus the clock lane, seven slots each
    for (genvar i = 0; i <= pixel_lane_pkg::LANE_COUNT; i++) begin : g_lane
        logic [6:0] slots;
        logic [6:0] slotsOut;
        if (i < pixel_lane_pkg::LANE_COUNT) begin : g_data
            assign slots = mappedLanes[i];
            assign serialLaneOut[i] = slotsOut;
        end else begin : g_clock
            assign slots = pixel_lane_pkg::CLK_LANE_PATTERN;
            assign clockLaneOut = slotsOut;
        end
        // Blanked until locked: unlocked output is not valid
        lane_slot_register u_lane (
            .pixelClock (pixelClockIn),
            .blank      (!lockSync2_q),
            .slotsIn    (slots),
            .slotsOut   (slotsOut)
        );
    end

    // Mclk domain

    // Power-down pin: the second flop drives the enable directly so
    // the worst path stays at two mclk periods, inside the limit
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pdSync1_q <= 1'b0;
            pdSync2_q <= 1'b0;
        end else begin
            pdSync1_q <= powerDown_n;
            pdSync2_q <= pdSync1_q;
        end
    end

    assign laneOutEnable = pdSync2_q;

    // Pixel clock activity, toggle crossed with two flops then edge
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            actSync1_q <= 1'b0;
            actSync2_q <= 1'b0;
            actSync3_q <= 1'b0;
        end else begin
            actSync1_q <= actDiv_q[1];
            actSync2_q <= actSync1_q;
            actSync3_q <= actSync2_q;
        end
    end

    // Idle timer: long silence means the pixel clock has gone away
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            idleCount_q <= pixel_lane_pkg::ACT_CNT_BITS'(
                pixel_lane_pkg::ACT_TIMEOUT);
        end else if (actSync2_q != actSync3_q) begin
            idleCount_q <= '0;
        end else if (idleCount_q != pixel_lane_pkg::ACT_CNT_BITS'(
                         pixel_lane_pkg::ACT_TIMEOUT)) begin
            idleCount_q <= idleCount_q + 1'b1;
        end
    end

    assign clockPresent = idleCount_q != pixel_lane_pkg::ACT_CNT_BITS'(
        pixel_lane_pkg::ACT_TIMEOUT);

    // Lock wait restarts on clock loss or power-down
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            lockCount_q <= '0;
        end else if (!pdSync2_q || !clockPresent) begin
            lockCount_q <= '0;
        end else if (lockCount_q != lockTarget) begin
            lockCount_q <= lockCount_q + 1'b1;
        end
    end

    // Ready only after the full wait with power and clock present
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            linkReady <= 1'b0;
        end else begin
            linkReady <= (lockCount_q == lockTarget) && pdSync2_q
                && clockPresent;
        end
    end

    // Checks

    a_lane_capture: assert property (
        @(posedge pixelClockIn) disable iff (!pixRstSync2_q)
        lockSync2_q |=> serialLaneOut == $past(mappedLanes))
        else $error("Lane words do not follow the captured word");

    a_clock_lane: assert property (
        @(posedge pixelClockIn) disable iff (!pixRstSync2_q)
        lockSync2_q |=> clockLaneOut == pixel_lane_pkg::CLK_LANE_PATTERN)
        else $error("Clock lane pattern wrong");

    a_slot_count: assert property (
        @(posedge pixelClockIn) disable iff (!pixRstSync2_q)
        lockSync2_q |=> serialLaneOut[0] ==
            {$past(capturedWord_q.green[0]), $past(capturedWord_q.red[5:0])})
        else $error("Lane zero slots wrong");

    a_timing_bits: assert property (
        @(posedge pixelClockIn) disable iff (!pixRstSync2_q)
        lockSync2_q |=>
            serialLaneOut[2][6:4] == $past({capturedWord_q.pixelDataValid,
                capturedWord_q.frameSync, capturedWord_q.lineSync}))
        else $error("Timing bits not carried");

    a_rising_pick: assert property (
        @(posedge pixelClockIn) disable iff (!pixRstSync2_q)
        useRising |=> capturedWord_q == $past(risingWord_q))
        else $error("Rising edge capture not used");

    a_falling_pick: assert property (
        @(posedge pixelClockIn) disable iff (!pixRstSync2_q)
        (!useRising || !HAS_STROBE_SELECT) |=>
            capturedWord_q == $past(fallingWord_q))
        else $error("Falling edge capture not used");

    a_same_format: assert property (
        @(posedge pixelClockIn) disable iff (!pixRstSync2_q)
        (lockSync2_q && $past(lockSync2_q)) |=>
            serialLaneOut == mapLanes($past(capturedWord_d, 2)))
        else $error("Lane format depends on capture edge");

    a_blank_unlocked: assert property (
        @(posedge pixelClockIn) disable iff (!pixRstSync2_q)
        !lockSync2_q |=> serialLaneOut == '0 && clockLaneOut == 7'h00)
        else $error("Lanes carry data before lock");

    a_pd_ready: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !laneOutEnable |=> !linkReady)
        else $error("Link ready while drivers disabled");

    a_clock_lost: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !clockPresent |=> !linkReady && lockCount_q == '0)
        else $error("Link ready without a pixel clock");

    a_pd_release: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !pdSync2_q |=> !linkReady && lockCount_q == '0)
        else $error("Power-down did not stop the link");

    a_pd_delay: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !powerDown_n ##1 !powerDown_n |=> !laneOutEnable)
        else $error("Drivers still enabled after power-down");

    a_lock_wait: assert property (
        @(posedge mclk) disable iff (!reset_n)
        lockCount_q != lockTarget |=> !linkReady)
        else $error("Ready before lock wait ended");

    a_lock_count: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (pdSync2_q && clockPresent && lockCount_q != lockTarget)
            |=> lockCount_q == $past(lockCount_q) + 1'b1)
        else $error("Lock counter stalled");

endmodule : pixel_lane_serializer

/* File: shared/pixel_lane_pkg.sv */
package pixel_lane_pkg;

    // Link geometry
    localparam int LANE_COUNT = 4;
    localparam int SLOT_COUNT = 7;
    localparam int WORD_BITS  = 28;

    // Clock lane pattern, slot 0 first: high for two slots, low for three, high for two
    localparam logic [6:0] CLK_LANE_PATTERN = 7'h63;

    // Timing against mclk
    localparam int MCLK_PERIOD_NS = 40;
    localparam int PD_TIME_NS     = 100;
    localparam int PD_CYCLES      = PD_TIME_NS / MCLK_PERIOD_NS;
    localparam int LOCK_TIME_MS   = 10;
    localparam int LOCK_CYCLES    =
        LOCK_TIME_MS * 1000000 / MCLK_PERIOD_NS;
    localparam int LOCK_CNT_BITS  = 18;
    localparam int ACT_TIMEOUT    = 16;
    localparam int ACT_CNT_BITS   = 5;

    // Field placement of timing bits on the lanes
    localparam int CTL_LANE     = 2;
    localparam int CTL_SLOT_LSB = 4;

    // Reset values
    localparam logic [1:0] ACT_DIV_RESET = 2'h0;

    // Parallel input word
    typedef struct packed {
        logic       spareCtl;
        logic       pixelDataValid;
        logic       frameSync;
        logic       lineSync;
        logic [7:0] blue;
        logic [7:0] green;
        logic [7:0] red;
    } pixel_word_type;

    // Slot words of the four data lanes
    typedef logic [LANE_COUNT-1:0][SLOT_COUNT-1:0] lane_words_type;

endpackage : pixel_lane_pkg

/* File: sim/lane_receiver_model.sv */
`timescale 1ns/1ps

module lane_receiver_model (
    input  wire logic                           pixelClockIn,
    input  wire pixel_lane_pkg::lane_words_type serialLaneOut,
    input  wire logic [6:0]                     clockLaneOut,
    input  wire logic                           laneOutEnable,
    output pixel_lane_pkg::pixel_word_type      rxWord,
    output logic      [6:0]                     rxClk,
    output logic                                rxValid
);
    pixel_lane_pkg::lane_words_type lw = '0;

    // Falling-edge receiver; a released driver shows the inverse of its
    // last level, so stale data can never pass for fresh
    always @(negedge pixelClockIn) begin
        if (laneOutEnable) begin
            lw    <= serialLaneOut;
            rxClk <= clockLaneOut;
        end else begin
            lw    <= ~lw;
            rxClk <= ~rxClk;
        end
        rxValid <= laneOutEnable && (clockLaneOut != 7'h00);
    end

    // Shared lane and slot map back to the parallel word
    assign rxWord.red   = {lw[3][1:0], lw[0][5:0]};
    assign rxWord.green = {lw[3][3:2], lw[1][4:0], lw[0][6]};
    assign rxWord.blue  = {lw[3][5:4], lw[2][3:0], lw[1][6:5]};
    assign rxWord.lineSync       = lw[2][4];
    assign rxWord.frameSync      = lw[2][5];
    assign rxWord.pixelDataValid = lw[2][6];
    assign rxWord.spareCtl       = lw[3][6];
endmodule : lane_receiver_model

/* File: sim/pixel_lane_serializer_bench.sv */
`timescale 1ns/1ps

module pixel_lane_serializer_bench;
    localparam int LOCK = 20;
    logic mclk         = 1'b0;
    logic pixelClockIn = 1'b0;
    logic reset_n      = 1'b0;
    logic strobeRising = 1'b1;
    logic powerDown_n  = 1'b1;
    logic fallPhase    = 1'b0;
    pixel_lane_pkg::pixel_word_type parallelPixelIn = '0;
    pixel_lane_pkg::pixel_word_type nextWord;
    pixel_lane_pkg::lane_words_type lanes [2];
    pixel_lane_pkg::pixel_word_type rxWord [2];
    pixel_lane_pkg::pixel_word_type hist [$];
    logic [6:0] clkLane [2];
    logic [6:0] rxClk   [2];
    logic       enable  [2];
    logic       ready   [2];
    logic       rxValid [2];
    int pos [2] = '{-1, -1};
    int hits [2] = '{0, 0};
    int err_total   = 0;
    int check_count = 0;
    int cycles      = 0;
    int seed        = 32'h1c72;
    int n           = 0;

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // Latest edge count at which lock may be seen after power-up
    function automatic int lockLimit();
        return LOCK + 12;
    endfunction : lockLimit

    // Clocks: 25 MHz system, 33 MHz pixel at an unrelated phase
    initial forever #20 mclk = ~mclk;
    initial begin
        #7;
        forever #15 pixelClockIn = ~pixelClockIn;
    end

    // Hang guard, well above the expected run length
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            end_sim();
        end
    end

    // Launch on the edge opposite capture; all-ones and zero words mixed in
    always @(pixelClockIn) begin
        if (pixelClockIn == fallPhase) begin
            n = n + 1;
            nextWord = 28'($random(seed));
            if (n % 37 == 0) nextWord = '1;
            if (n % 41 == 0) nextWord = '0;
            parallelPixelIn <= nextWord;
            hist.push_back(nextWord);
        end
    end

    // Instance 0 has strobe select, instance 1 is the falling-only variant
    for (genvar k = 0; k < 2; k++) begin : g_link
        pixel_lane_serializer #(
            .HAS_STROBE_SELECT (k == 0),
            .LOCK_CYCLES       (LOCK)
        ) u_pixel_lane_serializer (
            .mclk            (mclk),
            .reset_n         (reset_n),
            .pixelClockIn    (pixelClockIn),
            .parallelPixelIn (parallelPixelIn),
            .strobeRising    ((k == 0) ? strobeRising : 1'b1),
            .powerDown_n     (powerDown_n),
            .serialLaneOut   (lanes[k]),
            .clockLaneOut    (clkLane[k]),
            .laneOutEnable   (enable[k]),
            .linkReady       (ready[k])
        );
        lane_receiver_model u_lane_receiver_model (
            .pixelClockIn  (pixelClockIn),
            .serialLaneOut (lanes[k]),
            .clockLaneOut  (clkLane[k]),
            .laneOutEnable (enable[k]),
            .rxWord        (rxWord[k]),
            .rxClk         (rxClk[k]),
            .rxValid       (rxValid[k])
        );
        // Align once on the latest matching word, then demand every word
        always @(posedge pixelClockIn) begin
            if (!rxValid[k] || (k == 1 && !fallPhase)) begin
                pos[k] = -1;
            end else if (pos[k] < 0) begin
                for (int i = 0; i < hist.size(); i++) begin
                    if (hist[i] === rxWord[k]) pos[k] = i;
                end
                check("align", pos[k] >= 0, 1);
            end else begin
                pos[k]++;
                check("word", rxWord[k], hist[pos[k]]);
                check("clkLane", rxClk[k],
                      pixel_lane_pkg::CLK_LANE_PATTERN);
                hits[k]++;
            end
        end
    end

    task automatic wait_lock();
        int t;
        t = 0;
        while (ready[0] !== 1'b1 && t < 100) begin
            @(posedge mclk);
            t++;
        end
        check("lockWait", t >= LOCK && t <= lockLimit(), 1);
    endtask : wait_lock

    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        wait_lock();
        repeat (300) @(posedge pixelClockIn);
        // Power-down in mid-stream, then relock
        @(posedge mclk) powerDown_n <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 check("enable", enable[0], 0);
        @(posedge mclk);
        #1 check("ready", ready[0], 0);
        repeat (6) @(posedge pixelClockIn);
        #1 check("lanesOff", lanes[0], 0);
        check("clkOff", clkLane[0], 0);
        @(posedge mclk) powerDown_n <= 1'b1;
        wait_lock();
        repeat (200) @(posedge pixelClockIn);
        check("risingHits", hits[0] > 400, 1);
        // Falling capture: reset, new strobe level, fresh history
        @(posedge mclk);
        reset_n      <= 1'b0;
        fallPhase    <= 1'b1;
        strobeRising <= 1'b0;
        repeat (16) @(posedge mclk);
        // Drivers are off by now, so no word check reads a dropped entry
        hist.delete();
        reset_n <= 1'b1;
        wait_lock();
        repeat (300) @(posedge pixelClockIn);
        check("fallHits", hits[0] > 650, 1);
        check("fixedHits", hits[1] > 250, 1);
        end_sim();
    end
endmodule : pixel_lane_serializer_bench
